// *** dsm_defs.svh ***
// offsets, field positions and reset values of the diagnostic status mapper
// assumes byte addresses on an 8-bit register port, 32-bit data
`ifndef DSM_DEFS_SVH
`define DSM_DEFS_SVH

// ***********************************************
// register offsets
// ***********************************************
`define DSM_OFF_CTRL       8'h00
`define DSM_OFF_MAP_FAIL   8'h04
`define DSM_OFF_MAP_CHECK  8'h08
`define DSM_OFF_MAP_OFFSP  8'h0C
`define DSM_OFF_MAP_MAINT  8'h10
`define DSM_OFF_PRI_FAIL   8'h14
`define DSM_OFF_PRI_CHECK  8'h18
`define DSM_OFF_PRI_OFFSP  8'h1C
`define DSM_OFF_PRI_MAINT  8'h20
`define DSM_OFF_SUPPRESS   8'h24
`define DSM_OFF_DETECT_EN  8'h28
`define DSM_OFF_BCAST_EN   8'h2C
`define DSM_OFF_IRQ_STAT   8'h30
`define DSM_OFF_IRQ_MASK   8'h34
`define DSM_OFF_ACTIVE     8'h38

// ***********************************************
// fields
// ***********************************************
`define DSM_CTRL_MULTIBIT  0
`define DSM_CTRL_OOS       1
`define DSM_RANGE_TOP      5'h1F
`define DSM_CFG_MASK       32'h0000_FFFE
`define DSM_STAT_SENT      4
`define DSM_STAT_REFUSED   5
`define DSM_STAT_W         6

// ***********************************************
// reset values and priority thresholds
// ***********************************************
`define DSM_RST_MAP_FAIL   32'hF000_0000
`define DSM_RST_MAP_CHECK  32'h0F00_0000
`define DSM_RST_MAP_OFFSP  32'h00F0_0000
`define DSM_RST_MAP_MAINT  32'h000F_0000
`define DSM_RST_PRI        4'h0
`define DSM_PRI_SHOW       4'h1
`define DSM_PRI_SEND       4'h2

`endif

// *** dsm_pkg.sv ***
// types shared by the diagnostic status mapper files
// assumes nothing of its surroundings
package dsm_pkg;
  typedef logic [31:0] dsm_map_t;
  typedef logic [3:0]  dsm_pri_t;
  typedef logic [4:0]  dsm_bit_t;
  typedef logic [3:0]  dsm_sig_t;
endpackage

// *** dsm_classify.sv ***
// classifier: picks the status signal of one map bit and its bus fate
// assumes maps and priorities steady for the cycle; purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "dsm_defs.svh"

module dsm_classify (
  // maps in severity order
  input  wire dsm_pkg::dsm_map_t map_fail,
  input  wire dsm_pkg::dsm_map_t map_check,
  input  wire dsm_pkg::dsm_map_t map_offsp,
  input  wire dsm_pkg::dsm_map_t map_maint,
  // priorities in the same order
  input  wire dsm_pkg::dsm_pri_t pri_fail,
  input  wire dsm_pkg::dsm_pri_t pri_check,
  input  wire dsm_pkg::dsm_pri_t pri_offsp,
  input  wire dsm_pkg::dsm_pri_t pri_maint,
  // selection
  input  wire dsm_pkg::dsm_bit_t sel_bit,
  input  wire logic              bcast_ok,
  // verdict
  output var  dsm_pkg::dsm_sig_t sig,
  output var  dsm_pkg::dsm_pri_t sel_pri,
  output var  logic              show,
  output var  logic              send
);

  logic [3:0] hit;

  function automatic logic pri_at_least(input dsm_pkg::dsm_pri_t p, input dsm_pkg::dsm_pri_t lim);
    pri_at_least = (p >= lim);
  endfunction

  always_comb begin
    hit = {map_maint[sel_bit], map_offsp[sel_bit], map_check[sel_bit], map_fail[sel_bit]}; // R1
    sig = 4'h0;
    sel_pri = `DSM_RST_PRI;
    if (hit[0]) begin // R17
      sig = 4'h1;
      sel_pri = pri_fail;
    end else if (hit[1]) begin
      sig = 4'h2;
      sel_pri = pri_check;
    end else if (hit[2]) begin
      sig = 4'h4;
      sel_pri = pri_offsp;
    end else if (hit[3]) begin
      sig = 4'h8;
      sel_pri = pri_maint;
    end
    show = (|hit) && pri_at_least(sel_pri, `DSM_PRI_SHOW); // R5 R9 R10
    send = show && bcast_ok && pri_at_least(sel_pri, `DSM_PRI_SEND); // R8 R12
  end

endmodule
`default_nettype wire

// *** dsm_top.sv ***
// diagnostic status mapper: maps diagnostic events onto four status signals
// assumes events and register strobes come from logic on clk_sys
//
// Function
// R1: four maps, one per status signal
// R2: range bits 31..16, nibble defaults, bit 0 zero
// R3: bits 15..1 configurable area, cleared at reset
// R4: host switches out of service around map edits
// R5: range clear in all maps sends nothing
// R6: host keeps every range assigned somewhere
// R7: map change leaves active entries untouched
// R8: bus send only for priority 2..15
// R9: priority 1 shown locally, not sent
// R10: priority 0 events ignored entirely
// R11: separate writable priority per signal
// R12: suppress mask blocks bus, keeps local display
// R13: detect-enabled configurable bit records mapped event
// R14: broadcast-enabled configurable bit sends mapped event
// R15: range bit covers whole range
// R16: custom maps only after multi-bit alarm enabled
// R17: overlapping maps report most severe signal
`timescale 1ns/1ps
`default_nettype none
`include "dsm_defs.svh"

module dsm_top (
  // clock and reset
  input  wire  logic        clk_sys,
  input  wire  logic        rst_n,
  // register port
  input  wire  logic [7:0]  reg_addr,
  input  wire  logic [31:0] reg_wdata,
  input  wire  logic        reg_wr,
  input  wire  logic        reg_rd,
  output logic [31:0]       reg_rdata,
  // diagnostic event in
  input  wire  logic        evt_valid,
  input  wire  logic [3:0]  evt_range,
  input  wire  logic [3:0]  evt_cfg_bit,
  // reported status
  output logic              diag_valid,
  output logic [3:0]        diag_signal,
  output logic              diag_local,
  output logic              diag_bus,
  // interrupt
  output logic              irq
);

  // ***********************************************
  // registers
  // ***********************************************
  logic [1:0]                    ctrl_ff, nxt_ctrl;
  dsm_pkg::dsm_map_t             map_ff [4];
  dsm_pkg::dsm_map_t             nxt_map [4];
  dsm_pkg::dsm_pri_t             pri_ff [4];
  dsm_pkg::dsm_pri_t             nxt_pri [4];
  logic [31:0]                   supp_ff, nxt_supp;
  logic [15:1]                   det_ff, nxt_det;
  logic [15:1]                   bce_ff, nxt_bce;
  logic [`DSM_STAT_W-1:0]        stat_ff, nxt_stat;
  logic [`DSM_STAT_W-1:0]        mask_ff, nxt_mask;
  logic [3:0]                    act_ff, nxt_act;
  logic [31:0]                   rdata_ff, nxt_rdata;
  logic                          irq_ff, nxt_irq;
  logic                          dv_ff, nxt_dv;
  logic [3:0]                    dsig_ff, nxt_dsig;
  logic                          dloc_ff, nxt_dloc;
  logic                          dbus_ff, nxt_dbus;

  dsm_pkg::dsm_map_t             eff_map [4];
  dsm_pkg::dsm_bit_t             sel_bit;
  logic                          use_cfg;
  logic                          bcast_ok;
  dsm_pkg::dsm_sig_t             cls_sig;
  dsm_pkg::dsm_pri_t             cls_pri;
  logic                          cls_show;
  logic                          cls_send;
  logic                          map_wr_refused;

  localparam dsm_pkg::dsm_map_t MAP_RST [4] = '{`DSM_RST_MAP_FAIL, `DSM_RST_MAP_CHECK,
                                                `DSM_RST_MAP_OFFSP, `DSM_RST_MAP_MAINT};

  function automatic logic is_map_off(input logic [7:0] a, input logic [1:0] i);
    is_map_off = (a == (`DSM_OFF_MAP_FAIL + {4'h0, i, 2'b00}));
  endfunction

  function automatic logic is_pri_off(input logic [7:0] a, input logic [1:0] i);
    is_pri_off = (a == (`DSM_OFF_PRI_FAIL + {4'h0, i, 2'b00}));
  endfunction

  // ***********************************************
  // event selection
  // ***********************************************
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      eff_map[i] = ctrl_ff[`DSM_CTRL_MULTIBIT] ? map_ff[i] : MAP_RST[i]; // R16
    end
    use_cfg = (evt_cfg_bit != 4'h0) && det_ff[evt_cfg_bit]; // R13
    sel_bit = use_cfg ? {1'b0, evt_cfg_bit} : (`DSM_RANGE_TOP - {1'b0, evt_range}); // R15
    bcast_ok = !supp_ff[sel_bit] && (!use_cfg || bce_ff[evt_cfg_bit]); // R12 R14
  end

  dsm_classify u_classify (
    .map_fail  (eff_map[0]),
    .map_check (eff_map[1]),
    .map_offsp (eff_map[2]),
    .map_maint (eff_map[3]),
    .pri_fail  (pri_ff[0]),
    .pri_check (pri_ff[1]),
    .pri_offsp (pri_ff[2]),
    .pri_maint (pri_ff[3]),
    .sel_bit   (sel_bit),
    .bcast_ok  (bcast_ok),
    .sig       (cls_sig),
    .sel_pri   (cls_pri),
    .show      (cls_show),
    .send      (cls_send)
  );

  // ***********************************************
  // next state
  // ***********************************************
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_supp = supp_ff;
    nxt_det = det_ff;
    nxt_bce = bce_ff;
    nxt_mask = mask_ff;
    nxt_stat = stat_ff;
    nxt_act = act_ff;
    map_wr_refused = 1'b0;
    for (int i = 0; i < 4; i++) begin
      nxt_map[i] = map_ff[i];
      nxt_pri[i] = pri_ff[i];
    end
    if (reg_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (is_map_off(reg_addr, 2'(i))) begin
          if (ctrl_ff[`DSM_CTRL_OOS]) begin // R4
            nxt_map[i] = {reg_wdata[31:1], 1'b0}; // R2 R3
          end else begin
            map_wr_refused = 1'b1;
          end
        end
        if (is_pri_off(reg_addr, 2'(i))) begin
          nxt_pri[i] = reg_wdata[3:0]; // R11
        end
      end
      case (reg_addr)
        `DSM_OFF_CTRL:      nxt_ctrl = reg_wdata[1:0];
        `DSM_OFF_SUPPRESS:  nxt_supp = reg_wdata;
        `DSM_OFF_DETECT_EN: nxt_det = reg_wdata[15:1];
        `DSM_OFF_BCAST_EN:  nxt_bce = reg_wdata[15:1];
        `DSM_OFF_IRQ_STAT:  nxt_stat = stat_ff & ~reg_wdata[`DSM_STAT_W-1:0];
        `DSM_OFF_IRQ_MASK:  nxt_mask = reg_wdata[`DSM_STAT_W-1:0];
        `DSM_OFF_ACTIVE:    nxt_act = act_ff & ~reg_wdata[3:0];
        default:            nxt_ctrl = ctrl_ff;
      endcase
    end
    // events set after any clear, so a same-cycle set wins
    if (evt_valid && cls_show) begin
      nxt_act = nxt_act | cls_sig; // R7
      nxt_stat[3:0] = nxt_stat[3:0] | cls_sig;
      nxt_stat[`DSM_STAT_SENT] = nxt_stat[`DSM_STAT_SENT] | cls_send;
    end
    nxt_stat[`DSM_STAT_REFUSED] = nxt_stat[`DSM_STAT_REFUSED] | map_wr_refused;
    nxt_irq = |(nxt_stat & nxt_mask);
    // report latched at occurrence; later map edits do not touch it
    nxt_dv = evt_valid && cls_show; // R10
    nxt_dsig = nxt_dv ? cls_sig : dsig_ff; // R7
    nxt_dloc = nxt_dv; // R9
    nxt_dbus = nxt_dv && cls_send; // R8 R5
  end

  // ***********************************************
  // read mux
  // ***********************************************
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (reg_rd) begin
      for (int i = 0; i < 4; i++) begin
        if (is_map_off(reg_addr, 2'(i))) begin
          nxt_rdata = map_ff[i];
        end
        if (is_pri_off(reg_addr, 2'(i))) begin
          nxt_rdata = {28'h000_0000, pri_ff[i]};
        end
      end
      case (reg_addr)
        `DSM_OFF_CTRL:      nxt_rdata = {30'h0000_0000, ctrl_ff};
        `DSM_OFF_SUPPRESS:  nxt_rdata = supp_ff;
        `DSM_OFF_DETECT_EN: nxt_rdata = {16'h0000, det_ff, 1'b0};
        `DSM_OFF_BCAST_EN:  nxt_rdata = {16'h0000, bce_ff, 1'b0};
        `DSM_OFF_IRQ_STAT:  nxt_rdata = {26'h000_0000, stat_ff};
        `DSM_OFF_IRQ_MASK:  nxt_rdata = {26'h000_0000, mask_ff};
        `DSM_OFF_ACTIVE:    nxt_rdata = {28'h000_0000, act_ff};
        default:            nxt_rdata = nxt_rdata;
      endcase
    end
  end

  // ***********************************************
  // state registers
  // ***********************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        map_ff[i] <= MAP_RST[i];
        pri_ff[i] <= `DSM_RST_PRI;
      end
      supp_ff <= 32'h0000_0000;
      det_ff <= 15'h0000;
      bce_ff <= 15'h0000;
      stat_ff <= 6'h00;
      mask_ff <= 6'h00;
      act_ff <= 4'h0;
      rdata_ff <= 32'h0000_0000;
      irq_ff <= 1'b0;
      dv_ff <= 1'b0;
      dsig_ff <= 4'h0;
      dloc_ff <= 1'b0;
      dbus_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      for (int i = 0; i < 4; i++) begin
        map_ff[i] <= nxt_map[i];
        pri_ff[i] <= nxt_pri[i];
      end
      supp_ff <= nxt_supp;
      det_ff <= nxt_det;
      bce_ff <= nxt_bce;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      act_ff <= nxt_act;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
      dv_ff <= nxt_dv;
      dsig_ff <= nxt_dsig;
      dloc_ff <= nxt_dloc;
      dbus_ff <= nxt_dbus;
    end
  end

  assign reg_rdata = rdata_ff;
  assign diag_valid = dv_ff;
  assign diag_signal = dsig_ff;
  assign diag_local = dloc_ff;
  assign diag_bus = dbus_ff;
  assign irq = irq_ff;

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_evt_seen;
    evt_valid && cls_show;
  endsequence

  sequence s_evt_dropped;
    evt_valid && !cls_show;
  endsequence

  AST_PRI0_IGNORED: assert property (s_evt_dropped |=> !diag_valid && !diag_bus) // R10
    else $error("dropped event still reported");

  AST_PRI1_LOCAL: assert property (s_evt_seen ##0 (cls_pri == 4'h1) |=> diag_local && !diag_bus) // R9
    else $error("priority 1 event reached the bus");

  AST_SEND_RANGE: assert property (diag_bus |-> diag_local && $past(cls_pri) >= 4'h2) // R8
    else $error("bus send with priority below 2");

  AST_SUPPRESS: assert property (evt_valid && supp_ff[sel_bit] |=> !diag_bus) // R12
    else $error("suppressed event sent on bus");

  AST_SEVERITY: assert property (s_evt_seen ##0 map_ff[0][sel_bit] && ctrl_ff[0] |=> diag_signal == 4'h1) // R17
    else $error("most severe signal not chosen");

  AST_BIT0_ZERO: assert property (!map_ff[0][0] && !map_ff[1][0] && !map_ff[2][0] && !map_ff[3][0]) // R2
    else $error("map bit 0 set");

  AST_MAP_GUARD: assert property (reg_wr && !ctrl_ff[1] |=> $stable(map_ff[0]) && $stable(map_ff[1]) // R4
    && $stable(map_ff[2]) && $stable(map_ff[3]))
    else $error("map changed outside out of service");

  AST_HOLD_REPORT: assert property (!evt_valid |=> $stable(diag_signal)) // R7
    else $error("reported signal changed without event");

  AST_DEFAULT_MAP: assert property (s_evt_seen ##0 !ctrl_ff[0] && !use_cfg && evt_range < 4'h4 |=> diag_signal == 4'h1) // R16
    else $error("default map not used while feature off");

  AST_IRQ_LEVEL: assert property (irq == |(stat_ff & mask_ff))
    else $error("interrupt out of step with status");

endmodule
`default_nettype wire

// *** dsm_host_model.sv ***
// host side model: takes the status reports that the mapper sends on the bus
// assumes registered one-cycle diag_bus pulses on clk_sys
`timescale 1ns/1ps
`default_nettype none

module dsm_host_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // bus reports
  input  wire logic        diag_bus,
  input  wire logic [3:0]  diag_signal,
  // tally
  output var  logic [15:0] rx_count,
  output var  logic [3:0]  rx_signal
);
  // only pulses marked for the bus reach the host
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_count  <= 16'h0000;
      rx_signal <= 4'h0;
    end else if (diag_bus) begin
      rx_count  <= rx_count + 16'h0001;
      rx_signal <= diag_signal;
    end
  end
endmodule
`default_nettype wire

// *** dsm_top_tb.sv ***
// self-checking bench of the diagnostic status mapper
// assumes dsm_top and dsm_host_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "dsm_defs.svh"

module dsm_top_tb;
  logic        clk_sys     = 1'h0;
  logic        rst_n       = 1'h0;
  logic [7:0]  reg_addr    = 8'h00;
  logic [31:0] reg_wdata   = 32'h0000_0000;
  logic        reg_wr      = 1'h0;
  logic        reg_rd      = 1'h0;
  logic        evt_valid   = 1'h0;
  logic [3:0]  evt_range   = 4'h0;
  logic [3:0]  evt_cfg_bit = 4'h0;
  logic [31:0] reg_rdata;
  logic        diag_valid;
  logic        diag_local;
  logic        diag_bus;
  logic        irq;
  logic [3:0]  diag_signal;
  logic [15:0] rx_count;
  logic [3:0]  rx_signal;
  logic [15:0] exp_rx      = 16'h0000;
  int          failures    = 0;
  int          comparisons = 0;

  always #10 clk_sys = ~clk_sys;

  dsm_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt_valid(evt_valid),
    .evt_range(evt_range), .evt_cfg_bit(evt_cfg_bit), .diag_valid(diag_valid),
    .diag_signal(diag_signal), .diag_local(diag_local), .diag_bus(diag_bus), .irq(irq));

  dsm_host_model host (.clk_sys(clk_sys), .rst_n(rst_n), .diag_bus(diag_bus),
    .diag_signal(diag_signal), .rx_count(rx_count), .rx_signal(rx_signal));

  // ***********************************************
  // shared tasks
  // ***********************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk_sys);
    reg_wr    <= 1'h0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk_sys);
    reg_rd   <= 1'h0;
    #1;
    chk($sformatf("reg %h", a), reg_rdata & msk, exp);
  endtask

  // sig zero: nothing may be reported
  task automatic ev(input logic [3:0] rng, input logic [3:0] cfg, input logic [3:0] sig, input logic bus);
    @(posedge clk_sys);
    evt_valid   <= 1'h1;
    evt_range   <= rng;
    evt_cfg_bit <= cfg;
    @(posedge clk_sys);
    evt_valid   <= 1'h0;
    #1;
    chk("diag_valid", {31'h0, diag_valid}, {31'h0, sig != 4'h0});
    chk("diag_local", {31'h0, diag_local}, {31'h0, sig != 4'h0});
    chk("diag_bus", {31'h0, diag_bus}, {31'h0, bus});
    if (sig != 4'h0)
      chk("diag_signal", {28'h0, diag_signal}, {28'h0, sig});
    if (bus)
      exp_rx++;
  endtask

  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ***********************************************
  // scenarios
  // ***********************************************
  task automatic t_reset;
    rdchk(`DSM_OFF_MAP_FAIL, `DSM_RST_MAP_FAIL, 32'hFFFF_FFFF);
    rdchk(`DSM_OFF_MAP_CHECK, `DSM_RST_MAP_CHECK, 32'hFFFF_FFFF);
    rdchk(`DSM_OFF_MAP_OFFSP, `DSM_RST_MAP_OFFSP, 32'hFFFF_FFFF);
    rdchk(`DSM_OFF_MAP_MAINT, `DSM_RST_MAP_MAINT, 32'hFFFF_FFFF);
    rdchk(`DSM_OFF_PRI_FAIL, 32'h0000_0000, 32'hFFFF_FFFF);
    rdchk(8'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
    ev(4'h0, 4'h0, 4'h0, 1'h0);
  endtask

  task automatic t_priority;
    wr(`DSM_OFF_PRI_FAIL, 32'h0000_0001);
    ev(4'h1, 4'h0, 4'h1, 1'h0);
    wr(`DSM_OFF_PRI_FAIL, 32'h0000_000F);
    ev(4'h1, 4'h0, 4'h1, 1'h1);
    for (int i = 0; i < 4; i++)
      wr(`DSM_OFF_PRI_FAIL + 8'(4 * i), 32'(i + 2));
    for (int i = 0; i < 4; i++)
      rdchk(`DSM_OFF_PRI_FAIL + 8'(4 * i), 32'(i + 2), 32'hFFFF_FFFF);
    ev(4'h2, 4'h0, 4'h1, 1'h1);
  endtask

  task automatic t_ranges;
    for (int r = 0; r < 16; r++)
      ev(4'(r), 4'h0, 4'h1 << (r / 4), 1'h1);
  endtask

  task automatic t_maps;
    wr(`DSM_OFF_MAP_FAIL, 32'h0000_0000);
    rdchk(`DSM_OFF_MAP_FAIL, `DSM_RST_MAP_FAIL, 32'hFFFF_FFFF);
    rdchk(`DSM_OFF_IRQ_STAT, 32'h0000_0020, 32'h0000_0020);
    wr(`DSM_OFF_CTRL, 32'h0000_0002);
    wr(`DSM_OFF_MAP_FAIL, 32'hB000_0001);
    rdchk(`DSM_OFF_MAP_FAIL, 32'hB000_0000, 32'hFFFF_FFFF);
    wr(`DSM_OFF_MAP_CHECK, 32'h4F00_0000);
    ev(4'h1, 4'h0, 4'h1, 1'h1);
    wr(`DSM_OFF_CTRL, 32'h0000_0003);
    ev(4'h1, 4'h0, 4'h2, 1'h1);
    wr(`DSM_OFF_MAP_OFFSP, 32'hC0F0_0000);
    ev(4'h0, 4'h0, 4'h1, 1'h1);
    ev(4'h1, 4'h0, 4'h2, 1'h1);
    wr(`DSM_OFF_MAP_FAIL, 32'h9000_0000);
    ev(4'h2, 4'h0, 4'h0, 1'h0);
    wr(`DSM_OFF_MAP_FAIL, 32'hB000_0000);
    ev(4'h2, 4'h0, 4'h1, 1'h1);
  endtask

  task automatic t_cfg;
    wr(`DSM_OFF_DETECT_EN, 32'h0000_0008);
    rdchk(`DSM_OFF_DETECT_EN, 32'h0000_0008, 32'hFFFF_FFFF);
    wr(`DSM_OFF_MAP_OFFSP, 32'hC0F0_0008);
    ev(4'h0, 4'h3, 4'h4, 1'h0);
    wr(`DSM_OFF_BCAST_EN, 32'h0000_0008);
    ev(4'h0, 4'h3, 4'h4, 1'h1);
    ev(4'h0, 4'h5, 4'h1, 1'h1);
    wr(`DSM_OFF_SUPPRESS, 32'h8000_0000);
    ev(4'h0, 4'h0, 4'h1, 1'h0);
    wr(`DSM_OFF_SUPPRESS, 32'h0000_0000);
  endtask

  task automatic t_active_irq;
    wr(`DSM_OFF_ACTIVE, 32'h0000_000F);
    wr(`DSM_OFF_IRQ_STAT, 32'h0000_003F);
    ev(4'h0, 4'h0, 4'h1, 1'h1);
    wr(`DSM_OFF_MAP_FAIL, 32'h1000_0000);
    wr(`DSM_OFF_CTRL, 32'h0000_0001);
    rdchk(`DSM_OFF_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
    rdchk(`DSM_OFF_ACTIVE, 32'h0000_0001, 32'hFFFF_FFFF);
    ev(4'h0, 4'h0, 4'h4, 1'h1);
    wr(`DSM_OFF_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    wr(`DSM_OFF_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    rdchk(`DSM_OFF_IRQ_STAT, 32'h0000_0014, 32'h0000_0015);
  endtask

  // ***********************************************
  // run
  // ***********************************************
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    t_reset();
    t_priority();
    t_ranges();
    t_maps();
    t_cfg();
    t_active_irq();
    repeat (2) @(posedge clk_sys);
    #1;
    chk("rx_count", {16'h0, rx_count}, {16'h0, exp_rx});
    chk("rx_signal", {28'h0, rx_signal}, 32'h0000_0004);
    summarize();
  end
endmodule
`default_nettype wire
